// ===== logic/io_image_pkg.sv
// Shared constants and carriers for the Modbus I/O image and diagnostic LEDs.
// Assumes one 25 MHz clock and a synchronous active-high reset.
`default_nettype none
package io_image_pkg;
  // Modbus function codes served by the image.
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_INPUTS = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT_REG = 8'h04;
  localparam logic [7:0] FC_FORCE_COIL = 8'h05;
  localparam logic [7:0] FC_PRESET_REG = 8'h06;
  localparam logic [7:0] FC_FORCE_COILS = 8'h0F;
  localparam logic [7:0] FC_PRESET_REGS = 8'h10;
  // Exception answers; zero means success.
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  // Word map: discrete words at 0, analog inputs and outputs in their own windows.
  localparam logic [15:0] DISC_WORD_ADDR = 16'h0000;
  localparam logic [15:0] AI_BASE = 16'h0100;
  localparam logic [15:0] AO_BASE = 16'h0200;
  localparam int ETH_WORDS_PER_CH = 4;
  localparam int SER_WORDS_PER_CH = 1;
  localparam logic [1:0] ETH_STAT_WORD = 2'h0;
  localparam logic [1:0] ETH_DATA_WORD = 2'h1;
  // Status word bit positions.
  localparam int ST_UNDER_BIT = 0;
  localparam int ST_OVER_BIT = 1;
  localparam int ST_ERROR_BIT = 6;
  // Blink error codes and arguments.
  localparam logic [3:0] ERR_CODE_TABLE = 4'h1;
  localparam logic [7:0] ERR_ARG_OVERFLOW = 8'h01;
  localparam logic [3:0] ERR_CODE_BREAK = 4'h4;
  localparam logic [3:0] ERR_CODE_COUPLER = 4'h6;
  localparam logic [7:0] ERR_ARG_DIP = 8'h04;
  localparam int ERR_FAST_COUNT = 8;
  localparam int POR_FLASH_COUNT = 5;
  // Timing, in ns as designed, and derived cycle counts.
  localparam int CLK_NS = 40;
  localparam int FAST_HALF_NS = 50_000_000;
  localparam int SLOW_HALF_NS = 250_000_000;
  localparam int PAUSE_NS = 1_000_000_000;
  localparam int COM_HOLD_NS = 50_000_000;
  localparam int POR_WINDOW_NS = 100_000_000;
  localparam int FAST_HALF_CYC = FAST_HALF_NS / CLK_NS;
  localparam int SLOW_HALF_CYC = SLOW_HALF_NS / CLK_NS;
  localparam int PAUSE_CYC = PAUSE_NS / CLK_NS;
  localparam int COM_HOLD_CYC = COM_HOLD_NS / CLK_NS;
  localparam int POR_WINDOW_CYC = POR_WINDOW_NS / CLK_NS;
  // Request and answer carriers of the Modbus port.
  typedef struct packed {
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] data;
  } mb_req_s;
  typedef struct packed {
    logic [15:0] data;
    logic [7:0] exc;
  } mb_rsp_s;
  // Decoded analog word address.
  typedef struct packed {
    logic hit;
    logic [7:0] ch;
    logic is_stat;
    logic is_data;
  } ana_dec_s;
endpackage
`default_nettype wire

// ===== logic/pulse_train.sv
// Emits a counted burst of equal on/off flashes after a start pulse.
// Assumes start comes from logic on the same clock.
`default_nettype none
module pulse_train #(
  parameter int HALF_CYC = 4,
  parameter int COUNT = 5
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Control.
  input wire logic start,
  // Outputs.
  output logic led,
  output logic busy
);
  localparam int TW = $clog2(HALF_CYC + 1);
  localparam int LW = $clog2(2 * COUNT + 1);
  generate
    if (HALF_CYC < 1 || COUNT < 1) begin : g_bad
      $error("pulse_train needs positive period and count");
    end
  endgenerate
  logic [TW-1:0] tmr_reg;
  logic [LW-1:0] left_reg;

  // Each expiry of the half period toggles the lamp until the count is spent.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tmr_reg <= '0;
      left_reg <= '0;
      led <= 1'b0;
    end else if (left_reg == '0) begin
      led <= 1'b0;
      if (start) begin
        left_reg <= LW'(2 * COUNT);
        tmr_reg <= TW'(HALF_CYC - 1);
      end
    end else if (tmr_reg != '0) begin
      tmr_reg <= tmr_reg - 1'b1;
    end else begin
      led <= ~led;
      left_reg <= left_reg - 1'b1;
      tmr_reg <= TW'(HALF_CYC - 1);
    end
  end

  assign busy = (left_reg != '0);
endmodule // pulse_train
`default_nettype wire

// ===== logic/blink_encoder.sv
// Blinks an error report: fast burst, slow code pulses, slow argument pulses, pause.
// Assumes the error inputs come from logic on the same clock and stay stable.
`default_nettype none
module blink_encoder #(
  parameter int FAST_HALF = 4,
  parameter int SLOW_HALF = 8,
  parameter int PAUSE = 16,
  parameter int FAST_N = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Error to report.
  input wire logic err_active,
  input wire logic [3:0] err_code,
  input wire logic [7:0] err_arg,
  // Lamp.
  output logic led
);
  import io_image_pkg::*;
  localparam int TW = $clog2(PAUSE + SLOW_HALF + FAST_HALF + 1);
  generate
    if (FAST_HALF < 1 || SLOW_HALF < FAST_HALF || PAUSE < SLOW_HALF || FAST_N < 1) begin : g_bad
      $error("blink_encoder timing out of range");
    end
  endgenerate
  typedef enum logic [2:0] {
    BL_IDLE = 3'b000,
    BL_FAST = 3'b001,
    BL_GAP1 = 3'b011,
    BL_CODE = 3'b010,
    BL_GAP2 = 3'b110,
    BL_ARG = 3'b111,
    BL_PAUSE = 3'b101
  } blink_e;
  blink_e state_reg;
  logic [TW-1:0] tmr_reg;
  logic [8:0] left_reg;
  logic [3:0] code_reg;
  logic [7:0] arg_reg;

  // Sequencer: pulses toggle on each half period, then the next phase loads.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= BL_IDLE;
      tmr_reg <= '0;
      left_reg <= '0;
      code_reg <= '0;
      arg_reg <= '0;
      led <= 1'b0;
    end else begin
      case (state_reg)
        BL_IDLE: begin
          led <= 1'b0;
          if (err_active) begin
            code_reg <= err_code;
            arg_reg <= err_arg;
            left_reg <= 9'(2 * FAST_N);
            tmr_reg <= TW'(FAST_HALF - 1);
            state_reg <= BL_FAST;
          end
        end
        default: begin
          if (tmr_reg != '0) begin
            tmr_reg <= tmr_reg - 1'b1;
          end else if (left_reg != '0) begin
            led <= ~led;
            left_reg <= left_reg - 1'b1;
            tmr_reg <= (state_reg == BL_FAST) ? TW'(FAST_HALF - 1) : TW'(SLOW_HALF - 1);
          end else begin
            // Phase over: gaps are one slow period, then the next sequence loads.
            case (state_reg)
              BL_FAST: begin
                state_reg <= BL_GAP1;
                tmr_reg <= TW'(2 * SLOW_HALF - 1);
              end
              BL_GAP1: begin
                state_reg <= BL_CODE;
                left_reg <= {4'h0, code_reg, 1'b0};
                tmr_reg <= TW'(SLOW_HALF - 1);
              end
              BL_CODE: begin
                state_reg <= BL_GAP2;
                tmr_reg <= TW'(2 * SLOW_HALF - 1);
              end
              BL_GAP2: begin
                state_reg <= BL_ARG;
                left_reg <= {arg_reg, 1'b0};
                tmr_reg <= TW'(SLOW_HALF - 1);
              end
              BL_ARG: begin
                state_reg <= BL_PAUSE;
                tmr_reg <= TW'(PAUSE - 1);
              end
              default: state_reg <= BL_IDLE; // Repeats while the error persists.
            endcase
          end
        end
      endcase
    end
  end
endmodule // blink_encoder
`default_nettype wire

// ===== logic/io_image.sv
// Modbus I/O image of discrete and analog points, plus the coupler diagnostic LEDs.
// Assumes the Modbus port and terminal-side data share ref_clk; power and switch pins do not.
`default_nettype none
module io_image #(
  parameter int N_DO = 16,
  parameter int N_DI = 16,
  parameter int NUM_AI = 2,
  parameter int NUM_AO = 2,
  parameter bit ETH_LAYOUT = 1'b1,
  parameter int FAST_HALF = io_image_pkg::FAST_HALF_CYC,
  parameter int SLOW_HALF = io_image_pkg::SLOW_HALF_CYC,
  parameter int PAUSE = io_image_pkg::PAUSE_CYC,
  parameter int COM_HOLD = io_image_pkg::COM_HOLD_CYC,
  parameter int POR_WINDOW = io_image_pkg::POR_WINDOW_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Modbus request and answer, one item per request.
  input wire logic req_valid,
  input wire io_image_pkg::mb_req_s req,
  output logic rsp_valid,
  output io_image_pkg::mb_rsp_s rsp,
  // Terminal-side I/O image.
  input wire logic [N_DI-1:0] di_in,
  output logic [N_DO-1:0] do_out,
  input wire logic [NUM_AI-1:0][15:0] ai_data,
  input wire logic [NUM_AI-1:0] ai_under,
  input wire logic [NUM_AI-1:0] ai_over,
  input wire logic [NUM_AI-1:0] ai_error,
  output logic [NUM_AO-1:0][15:0] ao_data,
  // Terminal-bus condition.
  input wire logic bus_running,
  input wire logic bus_err,
  input wire logic [3:0] bus_err_code,
  input wire logic [7:0] bus_err_arg,
  input wire logic table_overflow,
  input wire logic break_seen,
  input wire logic [7:0] break_after,
  // Pins from outside the clock domain.
  input wire logic coupler_pwr_ok,
  input wire logic field_pwr_ok,
  input wire logic dip_invalid,
  // Network condition.
  input wire logic rx_frame,
  input wire logic dyn_addr_en,
  input wire logic ip_obtained,
  input wire logic arp_addressed,
  input wire logic wdg_running,
  input wire logic wdg_error,
  input wire logic comm_present,
  // Indicators.
  output logic run_led,
  output logic err_led,
  output logic pwr_left_led,
  output logic pwr_right_led,
  output logic com_led,
  output logic net_err_led,
  output logic watchdog_indicator
);
  import io_image_pkg::*;

  localparam int WPC = ETH_LAYOUT ? ETH_WORDS_PER_CH : SER_WORDS_PER_CH;
  localparam int NSYNC = 3;
  localparam int CW = $clog2(COM_HOLD + SLOW_HALF + 1);
  localparam int PW = $clog2(POR_WINDOW + 1);

  generate
    if (N_DO < 1 || N_DO > 16 || N_DI < 1 || N_DI > 16) begin : g_bad_disc
      $error("io_image serves one discrete word of up to 16 points");
    end
    if (NUM_AI < 1 || NUM_AO < 1 || NUM_AI * WPC > 256 || NUM_AO * WPC > 256) begin : g_bad_ana
      $error("io_image analog channel count out of range");
    end
  endgenerate

  // Decodes a word address inside an analog window of nch channels.
  function automatic ana_dec_s ana_decode(input logic [15:0] addr, input logic [15:0] base,
                                          input int nch);
    ana_dec_s d;
    logic [15:0] off;
    d = '0;
    off = addr - base;
    if (addr >= base && int'(off) < nch * WPC) begin
      d.hit = 1'b1;
      if (ETH_LAYOUT) begin
        d.ch = off[9:2];
        d.is_stat = (off[1:0] == ETH_STAT_WORD);
        d.is_data = (off[1:0] == ETH_DATA_WORD);
      end else begin
        d.ch = off[7:0];
        d.is_data = 1'b1;
      end
    end
    return d;
  endfunction

  // Pin synchronisers: two flip-flops before anything reads the level.
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign pin_raw = {dip_invalid, field_pwr_ok, coupler_pwr_ok};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate
  logic cpl_pwr_s;
  logic fld_pwr_s;
  logic dip_bad_s;
  assign cpl_pwr_s = sync2_reg[0];
  assign fld_pwr_s = sync2_reg[1];
  assign dip_bad_s = sync2_reg[2];

  // Analog input status words: only range and error bits are ever set.
  logic [NUM_AI-1:0][15:0] ai_status;
  generate
    for (gi = 0; gi < NUM_AI; gi++) begin : g_stat
      always_comb begin
        ai_status[gi] = 16'h0000;
        ai_status[gi][ST_UNDER_BIT] = ai_under[gi];
        ai_status[gi][ST_OVER_BIT] = ai_over[gi];
        ai_status[gi][ST_ERROR_BIT] = ai_error[gi];
      end
    end
  endgenerate

  // Request decode: builds the answer and the write strobes of this request.
  logic [15:0] do_word;
  logic [15:0] di_word;
  mb_rsp_s rsp_next;
  logic coil_we;
  logic coil_val;
  logic ao_we;
  logic [7:0] ao_ch;
  ana_dec_s dec_ai;
  ana_dec_s dec_ao;
  logic bit_ok_do;
  logic bit_ok_di;
  assign do_word = 16'(do_out);
  assign di_word = 16'(di_in);
  assign dec_ai = ana_decode(req.addr, AI_BASE, NUM_AI);
  assign dec_ao = ana_decode(req.addr, AO_BASE, NUM_AO);
  assign bit_ok_do = (int'(req.addr) < N_DO);
  assign bit_ok_di = (int'(req.addr) < N_DI);

  always_comb begin
    rsp_next.data = 16'h0000;
    rsp_next.exc = EXC_NONE;
    coil_we = 1'b0;
    coil_val = 1'b0;
    ao_we = 1'b0;
    ao_ch = dec_ao.ch;
    case (req.func)
      // Bit codes see discrete points only, so analog addresses are refused.
      FC_READ_COILS: begin
        if (bit_ok_do) rsp_next.data = {15'h0000, do_word[req.addr[3:0]]};
        else rsp_next.exc = EXC_ADDR;
      end
      FC_READ_INPUTS: begin
        if (bit_ok_di) rsp_next.data = {15'h0000, di_word[req.addr[3:0]]};
        else rsp_next.exc = EXC_ADDR;
      end
      FC_FORCE_COIL: begin
        if (!bit_ok_do) begin
          rsp_next.exc = EXC_ADDR;
        end else if (req.data == COIL_ON || req.data == COIL_OFF) begin
          coil_we = 1'b1;
          coil_val = (req.data == COIL_ON);
          rsp_next.data = req.data;
        end else begin
          rsp_next.exc = EXC_VALUE;
        end
      end
      FC_FORCE_COILS: begin
        if (bit_ok_do) begin
          coil_we = 1'b1;
          coil_val = req.data[0];
          rsp_next.data = {15'h0000, req.data[0]};
        end else begin
          rsp_next.exc = EXC_ADDR;
        end
      end
      FC_READ_HOLDING, FC_READ_INPUT_REG: begin
        if (req.addr == DISC_WORD_ADDR) begin
          // Holding space shows the output word, input space the input word.
          rsp_next.data = (req.func == FC_READ_HOLDING) ? do_word : di_word;
        end else if (dec_ai.hit) begin
          if (dec_ai.is_stat) rsp_next.data = ai_status[dec_ai.ch];
          else if (dec_ai.is_data) rsp_next.data = ai_data[dec_ai.ch];
        end else if (dec_ao.hit && req.func == FC_READ_HOLDING) begin
          if (dec_ao.is_data) rsp_next.data = ao_data[dec_ao.ch];
        end else begin
          rsp_next.exc = EXC_ADDR;
        end
      end
      FC_PRESET_REG, FC_PRESET_REGS: begin
        if (dec_ao.hit) begin
          // Control and reserved words are accepted but change nothing.
          ao_we = dec_ao.is_data;
          rsp_next.data = req.data;
        end else begin
          rsp_next.exc = EXC_ADDR;
        end
      end
      default: rsp_next.exc = EXC_FUNC;
    endcase
  end

  // Answer register: one cycle after the request.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) rsp <= rsp_next;
    end
  end

  // Discrete output image.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      do_out <= '0;
    end else if (req_valid && coil_we) begin
      do_out[req.addr[3:0]] <= coil_val;
    end
  end

  // Analog output data words; only the data word steers the output.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ao_data <= '0;
    end else if (req_valid && ao_we) begin
      ao_data[ao_ch] <= req.data;
    end
  end

  // Error selection for the blink report, most specific cause first.
  logic blink_active;
  logic [3:0] blink_code;
  logic [7:0] blink_arg;
  always_comb begin
    blink_active = 1'b1;
    blink_code = bus_err_code;
    blink_arg = bus_err_arg;
    if (dip_bad_s) begin
      blink_code = ERR_CODE_COUPLER;
      blink_arg = ERR_ARG_DIP;
    end else if (table_overflow) begin
      blink_code = ERR_CODE_TABLE;
      blink_arg = ERR_ARG_OVERFLOW;
    end else if (break_seen) begin
      blink_code = ERR_CODE_BREAK;
      blink_arg = break_after;
    end else if (!bus_err) begin
      blink_active = 1'b0;
    end
  end

  blink_encoder #(
    .FAST_HALF(FAST_HALF),
    .SLOW_HALF(SLOW_HALF),
    .PAUSE(PAUSE),
    .FAST_N(ERR_FAST_COUNT)
  ) u_blink (
    .ref_clk(ref_clk),
    .rst(rst),
    .err_active(blink_active),
    .err_code(blink_code),
    .err_arg(blink_arg),
    .led(err_led)
  );

  // Steady indicators for run, power and watchdog.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_led <= 1'b0;
      pwr_left_led <= 1'b0;
      pwr_right_led <= 1'b0;
      watchdog_indicator <= 1'b0;
    end else begin
      run_led <= bus_running && !blink_active;
      pwr_left_led <= cpl_pwr_s;
      pwr_right_led <= fld_pwr_s;
      watchdog_indicator <= wdg_running && !wdg_error && comm_present;
    end
  end

  // COM lamp: stretched receive activity, or a slow flash while no address.
  logic [CW-1:0] com_hold_reg;
  logic [CW-1:0] slow_tmr_reg;
  logic slow_ph_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      com_hold_reg <= '0;
      slow_tmr_reg <= '0;
      slow_ph_reg <= 1'b0;
      com_led <= 1'b0;
    end else begin
      if (rx_frame) com_hold_reg <= CW'(COM_HOLD);
      else if (com_hold_reg != '0) com_hold_reg <= com_hold_reg - 1'b1;
      if (slow_tmr_reg == '0) begin
        slow_tmr_reg <= CW'(SLOW_HALF - 1);
        slow_ph_reg <= ~slow_ph_reg;
      end else begin
        slow_tmr_reg <= slow_tmr_reg - 1'b1;
      end
      if (dyn_addr_en && !ip_obtained) com_led <= slow_ph_reg;
      else com_led <= (com_hold_reg != '0);
    end
  end

  // Power-on window: one five-flash burst at most, never afterwards.
  logic [PW-1:0] por_tmr_reg;
  logic por_armed_reg;
  logic por_start;
  logic por_flash;
  assign por_start = por_armed_reg && (arp_addressed || dip_bad_s);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      por_tmr_reg <= PW'(POR_WINDOW);
      por_armed_reg <= 1'b1;
    end else if (por_armed_reg) begin
      por_tmr_reg <= por_tmr_reg - 1'b1;
      if (por_start || por_tmr_reg == '0) por_armed_reg <= 1'b0;
    end
  end

  pulse_train #(
    .HALF_CYC(FAST_HALF),
    .COUNT(POR_FLASH_COUNT)
  ) u_por_flash (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(por_start),
    .led(por_flash),
    .busy()
  );

  // Network error lamp follows the burst and is otherwise dark.
  always_ff @(posedge ref_clk) begin
    if (rst) net_err_led <= 1'b0;
    else net_err_led <= por_flash;
  end
endmodule // io_image
`default_nettype wire

// ===== bench/io_image_checker.sv
// Concurrent checks on the Modbus image ports and the run and watchdog lamps.
// Assumes binding to io_image with one clock and a synchronous reset.
`default_nettype none
module io_image_checker #(
  parameter int NUM_AI = 2,
  parameter int NUM_AO = 2
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Modbus port.
  input wire logic req_valid,
  input wire io_image_pkg::mb_req_s req,
  input wire logic rsp_valid,
  input wire io_image_pkg::mb_rsp_s rsp,
  // Image.
  input wire logic [15:0] do_out,
  input wire logic [NUM_AI-1:0] ai_under,
  input wire logic [NUM_AI-1:0] ai_over,
  input wire logic [NUM_AI-1:0] ai_error,
  input wire logic [NUM_AO-1:0][15:0] ao_data,
  // Lamps and their causes.
  input wire logic bus_running,
  input wire logic run_led,
  input wire logic wdg_running,
  input wire logic wdg_error,
  input wire logic comm_present,
  input wire logic watchdog_indicator
);
  import io_image_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Every request gets exactly one answer on the next edge.
  a_answer_next: assert property (req_valid |=> rsp_valid)
    else $error("answer missing");
  a_answer_quiet: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  a_coil_on: assert property (req_valid && req.func == FC_FORCE_COIL && req.addr == 16'h0000 &&
    req.data == COIL_ON |=> do_out[0] && rsp.exc == EXC_NONE)
    else $error("coil not forced");
  a_analog_bits: assert property (req_valid && req.func == FC_READ_INPUTS &&
    req.addr == AI_BASE |=> rsp.exc == EXC_ADDR)
    else $error("bit code reached analog data");
  a_status_bits: assert property (req_valid && req.func == FC_READ_INPUT_REG &&
    req.addr == AI_BASE |=> rsp.data == {9'h000, $past(ai_error[0]), 4'h0, $past(ai_over[0]),
    $past(ai_under[0])})
    else $error("status word wrong");
  a_pad_zero: assert property (req_valid && req.func == FC_READ_HOLDING &&
    req.addr == AI_BASE + 16'h0002 |=> rsp.data == 16'h0000)
    else $error("spare word not zero");
  a_ao_write: assert property (req_valid && req.func == FC_PRESET_REG &&
    req.addr == AO_BASE + 16'h0001 |=> ao_data[0] == $past(req.data))
    else $error("analog output not written");
  a_run_cause: assert property (run_led |-> $past(bus_running))
    else $error("run lamp without running bus");
  a_wdg_cause: assert property (watchdog_indicator |->
    $past(wdg_running && !wdg_error && comm_present))
    else $error("watchdog lamp without clean watchdog");
  // Main scenarios reached.
  c_coil: cover property (req_valid && req.func == FC_FORCE_COIL);
  c_preset: cover property (req_valid && req.func == FC_PRESET_REGS);
  c_run: cover property (run_led);
endmodule // io_image_checker
`default_nettype wire

// ===== bench/mb_master.sv
// Modbus master stand-in: presents one request item for each cycle that go is high.
// Assumes the bench changes go and cmd just after a falling clock edge.
`default_nettype none
module mb_master (
  // Command from the bench.
  input wire logic go,
  input wire io_image_pkg::mb_req_s cmd,
  // Request to the image.
  output logic req_valid,
  output io_image_pkg::mb_req_s req
);
  // Idle lines show the inverse command so a stale request never looks valid.
  // Analog windows are only sent bit codes by deliberate refusal probes.
  assign req_valid = go;
  assign req = go ? cmd : ~cmd;
endmodule // mb_master
`default_nettype wire

// ===== bench/test_io_image.sv
// Self-checking bench for the Modbus I/O image and its diagnostic lamps.
// Assumes the package, the design, the master stand-in and the checker are compiled first.
`default_nettype none
module test_io_image;
  timeunit 1ns;
  timeprecision 1ns;
  import io_image_pkg::*;
  logic ref_clk, rst, go, req_valid, rsp_valid, bus_running, bus_err, table_overflow;
  logic break_seen, coupler_pwr_ok, field_pwr_ok, dip_invalid, rx_frame, dyn_addr_en;
  logic ip_obtained, arp_addressed, wdg_running, wdg_error, comm_present, run_led, err_led;
  logic pwr_left_led, pwr_right_led, com_led, net_err_led, watchdog_indicator;
  logic [3:0] bus_err_code;
  logic [7:0] bus_err_arg, break_after;
  logic [15:0] di_in, do_out, w, bs;
  logic [1:0][15:0] ai_data, ao_data;
  logic [1:0] ai_under, ai_over, ai_error;
  mb_req_s cmd, req;
  mb_rsp_s rsp;
  int num_errors, cmp_count, dmod, bi, rises;
  // Master stand-in and the image, with short lamp timings.
  mb_master u_mb_master (.go, .cmd, .req_valid, .req);
  io_image #(.FAST_HALF(4), .SLOW_HALF(8), .PAUSE(16), .COM_HOLD(8), .POR_WINDOW(64))
    u_io_image (.ref_clk, .rst, .req_valid, .req, .rsp_valid, .rsp, .di_in, .do_out,
    .ai_data, .ai_under, .ai_over, .ai_error, .ao_data, .bus_running, .bus_err,
    .bus_err_code, .bus_err_arg, .table_overflow, .break_seen, .break_after,
    .coupler_pwr_ok, .field_pwr_ok, .dip_invalid, .rx_frame, .dyn_addr_en, .ip_obtained,
    .arp_addressed, .wdg_running, .wdg_error, .comm_present, .run_led, .err_led,
    .pwr_left_led, .pwr_right_led, .com_led, .net_err_led, .watchdog_indicator);
  // Free-running 25 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    results();
  end
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // One request item; the answer is looked at one cycle later, ed below zero skips data.
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, d, input int ed,
    input logic [7:0] ee);
    @(negedge ref_clk);
    go = 1'b1;
    cmd = '{f, a, d};
    @(negedge ref_clk);
    go = 1'b0;
    chk(rsp_valid === 1'b1 && rsp.exc === ee && (ed < 0 || rsp.data === 16'(ed)), "answer");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Reset, then discrete, analog and lamp tests.
  initial begin
    void'($urandom(27361));
    {go, rx_frame, bus_err, table_overflow, break_seen, dip_invalid, arp_addressed} = '0;
    {dyn_addr_en, ip_obtained, wdg_error, bus_err_code, bus_err_arg, break_after} = '0;
    {bus_running, coupler_pwr_ok, field_pwr_ok, wdg_running, comm_present} = '1;
    cmd = '0;
    di_in = 16'($urandom);
    ai_data = $urandom;
    {ai_under, ai_over, ai_error} = 6'($urandom);
    rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    for (int k = 0; k < 16; k++) begin
      bi = $urandom_range(15);
      w = k[0] ? COIL_ON : COIL_OFF;
      dmod[bi] = k[0];
      if (k[1]) xfer(FC_FORCE_COILS, 16'(bi), 16'(k[0]), k[0], EXC_NONE);
      else xfer(FC_FORCE_COIL, 16'(bi), w, w, EXC_NONE);
      xfer(FC_READ_COILS, 16'(bi), '0, k[0], EXC_NONE);
    end
    chk(do_out === 16'(dmod), "outputs");
    xfer(FC_READ_HOLDING, DISC_WORD_ADDR, '0, dmod, EXC_NONE);
    xfer(FC_READ_INPUT_REG, DISC_WORD_ADDR, '0, di_in, EXC_NONE);
    xfer(FC_READ_INPUTS, 16'h0005, '0, di_in[5], EXC_NONE);
    xfer(FC_READ_COILS, 16'h0010, '0, -1, EXC_ADDR);
    xfer(FC_FORCE_COIL, 16'h0000, 16'h1234, -1, EXC_VALUE);
    $display("test discrete done");
    for (int c = 0; c < 2; c++) begin
      w = 16'($urandom);
      bs = AI_BASE + 16'(4 * c);
      xfer(FC_READ_INPUT_REG, bs, '0, {ai_error[c], 4'h0, ai_over[c], ai_under[c]}, 0);
      xfer(FC_READ_HOLDING, bs + 16'h0001, '0, ai_data[c], EXC_NONE);
      xfer(FC_READ_INPUT_REG, bs + 16'h0003, '0, 0, EXC_NONE);
      xfer(FC_READ_HOLDING, bs + 16'h0002, '0, 0, EXC_NONE);
      xfer(FC_READ_INPUTS, bs, '0, -1, EXC_ADDR);
      bs = AO_BASE + 16'(4 * c);
      xfer(c ? FC_PRESET_REGS : FC_PRESET_REG, bs + 16'h0001, w, w, EXC_NONE);
      xfer(FC_PRESET_REG, bs, 16'hFFFF, 16'hFFFF, EXC_NONE);
      xfer(FC_READ_HOLDING, bs, '0, 0, EXC_NONE);
      chk(ao_data[c] === w, "analog output");
    end
    $display("test analog done");
    repeat (4) @(negedge ref_clk);
    chk(run_led === 1'b1 && watchdog_indicator === 1'b1, "run lamps");
    chk(pwr_left_led === 1'b1 && pwr_right_led === 1'b1, "power lamps");
    {field_pwr_ok, wdg_error, rx_frame} = 3'h3;
    @(negedge ref_clk);
    rx_frame = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(pwr_left_led === 1'b1 && pwr_right_led === 1'b0, "field lamp");
    chk(watchdog_indicator === 1'b0 && com_led === 1'b1, "link lamps");
    repeat (8) @(negedge ref_clk);
    chk(com_led === 1'b0, "idle link lamp");
    dyn_addr_en = 1'b1;
    repeat (64) begin
      @(negedge ref_clk);
      rises += com_led;
    end
    chk(rises > 16 && rises < 48, "address wait flash");
    dyn_addr_en = 1'b0;
    {bus_err, bus_err_code, bus_err_arg, break_seen, break_after, table_overflow} = 23'($urandom);
    {dip_invalid, arp_addressed} = 2'h3;
    {rises, bi} = '0;
    repeat (560) begin
      @(negedge ref_clk);
      rises += (err_led && !w[0]);
      w[0] = err_led;
      if (net_err_led !== 1'b0) bi++;
    end
    chk(rises >= 18 && rises <= 36, "blink report");
    chk(bi == 0 && run_led === 1'b0, "error lamps");
    // A second reset opens a new power-on window while an address hit is pending.
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    {rst, rises} = '0;
    repeat (64) begin
      @(negedge ref_clk);
      rises += (net_err_led && !bs[0]);
      bs[0] = net_err_led;
    end
    chk(rises == 5, "power-on flash");
    $display("test lamps done");
    results();
  end
endmodule // test_io_image
bind io_image io_image_checker #(.NUM_AI(NUM_AI), .NUM_AO(NUM_AO)) u_io_image_checker (
  .ref_clk, .rst, .req_valid, .req, .rsp_valid, .rsp, .do_out, .ai_under, .ai_over,
  .ai_error, .ao_data, .bus_running, .run_led, .wdg_running, .wdg_error, .comm_present,
  .watchdog_indicator);
`default_nettype wire
